// ==== src/temp_ctrl_defs.svh ====
// Offsets, field positions, reset values and timing counts of the sensor controller
`ifndef TEMP_CTRL_DEFS_SVH
`define TEMP_CTRL_DEFS_SVH
`define OFS_CONFIG 8'h00
`define OFS_RATE 8'h04
`define OFS_STATUS 8'h08
`define OFS_ONESHOT 8'h0c
`define OFS_LOCAL 8'h10
`define OFS_REMOTE 8'h14
`define OFS_LOC_OT 8'h18
`define OFS_REM_OT 8'h1c
`define OFS_REM_HIGH 8'h20
`define OFS_REM_LOW 8'h24
`define OFS_LINK 8'h28
`define CFG_EXT_RES 0
`define CFG_EXT_RANGE 3
`define CFG_DIODE_SUB 5
`define CFG_HALT 6
`define CFG_ALERT_MASK 7
`define CFG_RESET 8'h00
`define RATE_RESET 2'h2
`define RATE_4HZ 2'h2
`define LIMIT_OT_RESET 8'h55
`define LIMIT_HIGH_RESET 8'h46
`define LIMIT_LOW_RESET 8'h00
`define CRIT_T0 8'h50
`define CRIT_T1 8'h55
`define CRIT_T2 8'h5a
`define CRIT_T3 8'h64
`define FLOOR_NORMAL 11'sh000
`define FLOOR_EXT 11'sh600
`define CLK_MHZ 100
`define CONV_WINDOW_MS 60
`define CONV_WINDOW_CYC (`CONV_WINDOW_MS * 1000 * `CLK_MHZ)
`define RATE_8HZ_MS 125
`define RATE_8HZ_CYC (`RATE_8HZ_MS * 1000 * `CLK_MHZ)
`endif

// ==== src/temp_ctrl_pkg.sv ====
// Types shared by the sensor controller
package temp_ctrl_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOCAL = 3'b010,
        ST_REMOTE = 3'b100
    } conv_state_t;
    typedef struct packed {
        logic alert_mask;
        logic halt;
        logic diode_sub;
        logic ext_range;
        logic ext_res;
    } cfg_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } ahb_req_t;
endpackage : temp_ctrl_pkg

// ==== src/dual_temp_conversion_alarm_ctrl.sv ====
// Conversion sequencer, result registers and alarm outputs with an AHB-Lite register slave
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "temp_ctrl_defs.svh"
module dual_temp_conversion_alarm_ctrl #(
    parameter int unsigned CONV_WINDOW_CYC = `CONV_WINDOW_CYC,
    parameter int unsigned RATE_8HZ_CYC = `RATE_8HZ_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic reset_pin,
    input wire logic hw_standby_n,
    input wire logic overtemp_source_select,
    input wire logic overtemp_source_open,
    input wire logic alert_select,
    input wire logic [1:0] crit_strap,
    input wire logic [10:0] local_adc,
    input wire logic [10:0] remote_adc,
    output logic remote_diode_sub,
    output logic [2:0] adc_channel,
    input wire logic serial_clock_line,
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe,
    output logic overtemp_alarm_n_out,
    output logic overtemp_alarm_n_oe,
    output logic alert_n_out,
    output logic alert_n_oe
);
    temp_ctrl_pkg::conv_state_t state_q;
    temp_ctrl_pkg::cfg_t cfg_q;
    temp_ctrl_pkg::ahb_req_t req_q;
    logic [1:0] rate_q;
    logic [7:0] loc_ot_q, rem_ot_q, rem_high_q, rem_low_q;
    logic [7:0] local_q;
    logic [10:0] remote_q;
    logic [10:0] local_hold_q, local_fl, remote_fl;
    logic [31:0] win_cnt_q, per_cnt_q;
    logic oneshot_q, run_oneshot_q, alert_latch_q;
    logic [7:0] link_edges_q;
    logic [1:0] rst_s, hw_standby_n_s, sel_s, open_s, alsel_s, sck_s, sda_s;
    logic [3:0] crit_s;
    logic sck_prev_q;
    logic soft_rst, standby, start_seq, win_done, seq_done, halt_abort, seq_abort;
    logic [7:0] crit_lim;
    logic ot_local, ot_remote, ot_any, rem_viol, stat_read;
    logic [31:0] period_cyc;

    function automatic logic [10:0] apply_floor(input logic [10:0] raw, input logic ext);
        logic [10:0] floor_v;
        floor_v = ext ? `FLOOR_EXT : `FLOOR_NORMAL;
        apply_floor = ($signed(raw) < $signed(floor_v)) ? floor_v : raw;
    endfunction : apply_floor

    function automatic logic above(input logic [7:0] t, input logic [7:0] lim);
        above = $signed(t) > $signed(lim);
    endfunction : above

    // Pin synchronisers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_s <= 2'h0;
            hw_standby_n_s <= 2'h3;
            sel_s <= 2'h0;
            open_s <= 2'h0;
            alsel_s <= 2'h3;
            sck_s <= 2'h3;
            sda_s <= 2'h3;
            crit_s <= 4'h0;
        end else begin
            rst_s <= {rst_s[0], reset_pin};
            hw_standby_n_s <= {hw_standby_n_s[0], hw_standby_n};
            sel_s <= {sel_s[0], overtemp_source_select};
            open_s <= {open_s[0], overtemp_source_open};
            alsel_s <= {alsel_s[0], alert_select};
            sck_s <= {sck_s[0], serial_clock_line};
            sda_s <= {sda_s[0], serial_data_line_in};
            crit_s <= {crit_s[1:0], crit_strap};
        end
    end

    assign soft_rst = rst_s[1];
    assign standby = !hw_standby_n_s[1];

    always_comb begin
        case (crit_s[3:2])
            2'h0: crit_lim = `CRIT_T0;
            2'h1: crit_lim = `CRIT_T1;
            2'h2: crit_lim = `CRIT_T2;
            default: crit_lim = `CRIT_T3;
        endcase
    end

    // Serial link: edge activity only, data line never pulled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sck_prev_q <= 1'b1;
            link_edges_q <= 8'h00;
        end else begin
            sck_prev_q <= sck_s[1];
            if (soft_rst)
                link_edges_q <= 8'h00;
            else if (sck_s[1] && !sck_prev_q)
                link_edges_q <= link_edges_q + 8'h01;
        end
    end
    assign serial_data_line_out = 1'b0;
    assign serial_data_line_oe = 1'b0;

    // AHB-Lite slave, zero wait states
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign stat_read = hsel && hready && htrans[1] && !hwrite && haddr[7:0] == `OFS_STATUS;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            req_q <= '0;
        else if (hready)
            req_q <= '{hsel && htrans[1], hwrite, haddr[7:0]};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= 5'(`CFG_RESET);
            rate_q <= `RATE_RESET;
            loc_ot_q <= `LIMIT_OT_RESET;
            rem_ot_q <= `LIMIT_OT_RESET;
            rem_high_q <= `LIMIT_HIGH_RESET;
            rem_low_q <= `LIMIT_LOW_RESET;
        end else if (soft_rst) begin
            cfg_q <= 5'(`CFG_RESET);
            rate_q <= `RATE_RESET;
            loc_ot_q <= `LIMIT_OT_RESET;
            rem_ot_q <= `LIMIT_OT_RESET;
            rem_high_q <= `LIMIT_HIGH_RESET;
            rem_low_q <= `LIMIT_LOW_RESET;
        end else if (req_q.valid && req_q.write) begin
            case (req_q.addr)
                `OFS_CONFIG: cfg_q <= '{hwdata[`CFG_ALERT_MASK], hwdata[`CFG_HALT],
                    hwdata[`CFG_DIODE_SUB], hwdata[`CFG_EXT_RANGE], hwdata[`CFG_EXT_RES]};
                `OFS_RATE: rate_q <= hwdata[1:0];
                `OFS_LOC_OT: loc_ot_q <= hwdata[7:0];
                `OFS_REM_OT: rem_ot_q <= hwdata[7:0];
                `OFS_REM_HIGH: rem_high_q <= hwdata[7:0];
                `OFS_REM_LOW: rem_low_q <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready) begin
            hrdata <= 32'h0000_0000;
            if (hsel && htrans[1] && !hwrite) begin
                case (haddr[7:0])
                    `OFS_CONFIG: hrdata[7:0] <= {cfg_q.alert_mask, cfg_q.halt,
                        cfg_q.diode_sub, 1'b0, cfg_q.ext_range, 2'b00, cfg_q.ext_res};
                    `OFS_RATE: hrdata[1:0] <= rate_q;
                    `OFS_STATUS: hrdata[7:0] <= {!state_q[0], 2'b00,
                        above(remote_q[10:3], rem_high_q), $signed(remote_q[10:3]) <
                        $signed(rem_low_q), alert_latch_q, ot_remote, ot_local};
                    `OFS_LOCAL: hrdata[7:0] <= local_q;
                    `OFS_REMOTE: hrdata[10:0] <= remote_q;
                    `OFS_LOC_OT: hrdata[7:0] <= loc_ot_q;
                    `OFS_REM_OT: hrdata[7:0] <= rem_ot_q;
                    `OFS_REM_HIGH: hrdata[7:0] <= rem_high_q;
                    `OFS_REM_LOW: hrdata[7:0] <= rem_low_q;
                    `OFS_LINK: hrdata[7:0] <= link_edges_q;
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // One-shot request, dropped in hardware standby
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            oneshot_q <= 1'b0;
        else if (soft_rst || standby)
            oneshot_q <= 1'b0;
        else if (req_q.valid && req_q.write && req_q.addr == `OFS_ONESHOT)
            oneshot_q <= 1'b1;
        else if (start_seq)
            oneshot_q <= 1'b0;
    end

    // Autonomous rate timer: 8Hz period doubled per step down
    assign period_cyc = RATE_8HZ_CYC << (2'h3 - rate_q);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            per_cnt_q <= 32'h0000_0000;
        else if (soft_rst || standby || cfg_q.halt)
            per_cnt_q <= 32'h0000_0000;
        else if (per_cnt_q != 32'h0000_0000)
            per_cnt_q <= per_cnt_q - 32'h0000_0001;
        else if (start_seq)
            per_cnt_q <= period_cyc - 32'h0000_0001;
    end

    assign start_seq = state_q[0] && !standby && !soft_rst
        && (oneshot_q || (!cfg_q.halt && per_cnt_q == 32'h0000_0000));
    assign win_done = win_cnt_q == CONV_WINDOW_CYC - 1;
    // Halt interrupts an autonomous sequence; a one-shot run under halt completes, standby aborts any run
    assign halt_abort = cfg_q.halt && !run_oneshot_q && !state_q[0];
    assign seq_abort = soft_rst || standby || halt_abort;
    assign seq_done = state_q[2] && win_done && !seq_abort;

    // Sequencer: local window then remote window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= temp_ctrl_pkg::ST_IDLE;
            win_cnt_q <= 32'h0000_0000;
            run_oneshot_q <= 1'b0;
            local_hold_q <= 11'h000;
        end else if (seq_abort) begin
            state_q <= temp_ctrl_pkg::ST_IDLE;
            win_cnt_q <= 32'h0000_0000;
        end else begin
            case (state_q)
                temp_ctrl_pkg::ST_IDLE: begin
                    if (start_seq) begin
                        state_q <= temp_ctrl_pkg::ST_LOCAL;
                        run_oneshot_q <= oneshot_q;
                    end
                end
                temp_ctrl_pkg::ST_LOCAL: begin
                    win_cnt_q <= win_done ? 32'h0000_0000 : win_cnt_q + 32'h0000_0001;
                    if (win_done) begin
                        local_hold_q <= local_adc;
                        state_q <= temp_ctrl_pkg::ST_REMOTE;
                    end
                end
                temp_ctrl_pkg::ST_REMOTE: begin
                    win_cnt_q <= win_done ? 32'h0000_0000 : win_cnt_q + 32'h0000_0001;
                    if (win_done)
                        state_q <= temp_ctrl_pkg::ST_IDLE;
                end
                default: state_q <= temp_ctrl_pkg::ST_IDLE;
            endcase
        end
    end
    assign adc_channel = state_q;
    assign remote_diode_sub = cfg_q.diode_sub;

    assign local_fl = apply_floor(local_hold_q, cfg_q.ext_range);
    assign remote_fl = apply_floor(remote_adc, cfg_q.ext_range);

    // Result registers, loaded only at sequence end and cleared by the reset pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            local_q <= 8'h00;
            remote_q <= 11'h000;
        end else if (soft_rst) begin
            local_q <= 8'h00;
            remote_q <= 11'h000;
        end else if (seq_done) begin
            local_q <= local_fl[10:3];
            if (cfg_q.ext_res && (run_oneshot_q || rate_q <= `RATE_4HZ))
                remote_q <= remote_fl;
            else
                remote_q <= {remote_fl[10:3], 3'b000};
        end
    end

    // Overtemperature alarm
    assign ot_local = above(local_q, loc_ot_q) || above(local_q, crit_lim);
    assign ot_remote = above(remote_q[10:3], rem_ot_q) || above(remote_q[10:3], crit_lim);
    assign ot_any = open_s[1] ? (ot_local || ot_remote)
        : (sel_s[1] ? ot_remote : ot_local);
    assign overtemp_alarm_n_out = 1'b0;
    assign overtemp_alarm_n_oe = ot_any;

    // Alert: latched until status read, or comparator on remote limits
    assign rem_viol = above(remote_q[10:3], rem_high_q)
        || $signed(remote_q[10:3]) < $signed(rem_low_q);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            alert_latch_q <= 1'b0;
        else if (soft_rst)
            alert_latch_q <= 1'b0;
        else if (rem_viol)
            alert_latch_q <= 1'b1;
        else if (stat_read)
            alert_latch_q <= 1'b0;
    end
    assign alert_n_out = 1'b0;
    assign alert_n_oe = !cfg_q.alert_mask
        && (alsel_s[1] ? alert_latch_q : rem_viol);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_ot_src;
        !open_s[1] && sel_s[1] |-> overtemp_alarm_n_oe == ot_remote;
    endproperty
    a_ot_src: assert property (p_ot_src) else $error("overtemp source wrong");
    property p_od;
        overtemp_alarm_n_out == 1'b0 && alert_n_out == 1'b0;
    endproperty
    a_od: assert property (p_od) else $error("open drain drives high");
    property p_crit;
        !open_s[1] && !sel_s[1] && above(local_q, crit_lim) |-> overtemp_alarm_n_oe;
    endproperty
    a_crit: assert property (p_crit) else $error("strap threshold missed");
    property p_cmp;
        !alsel_s[1] && !cfg_q.alert_mask |-> alert_n_oe == rem_viol;
    endproperty
    a_cmp: assert property (p_cmp) else $error("comparator alert wrong");
    property p_latch;
        alsel_s[1] && !cfg_q.alert_mask && alert_n_oe && !stat_read && !soft_rst
            |=> alert_n_oe || cfg_q.alert_mask || !alsel_s[1];
    endproperty
    a_latch: assert property (p_latch) else $error("alert dropped early");
    property p_hw_standby_n;
        standby && !soft_rst |=> $stable(local_q) && $stable(remote_q) && state_q[0];
    endproperty
    a_hw_standby_n: assert property (p_hw_standby_n) else $error("standby changed state");
    property p_stable;
        !seq_done && !soft_rst |=> $stable(remote_q) && $stable(local_q);
    endproperty
    a_stable: assert property (p_stable) else $error("results changed mid sequence");
    property p_seq;
        state_q[1] && win_done && !seq_abort |=> state_q[2];
    endproperty
    a_seq: assert property (p_seq) else $error("remote window skipped");
    property p_fast;
        seq_done && !soft_rst && rate_q > `RATE_4HZ && !run_oneshot_q
            |=> remote_q[2:0] == 3'b000;
    endproperty
    a_fast: assert property (p_fast) else $error("fraction kept at fast rate");
    property p_busy;
        start_seq |=> !state_q[0] || standby || soft_rst;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not raised");
    c_seq: cover property (seq_done);
    c_ot: cover property (overtemp_alarm_n_oe);
    c_alert: cover property (alert_n_oe ##1 !alert_n_oe);
endmodule : dual_temp_conversion_alarm_ctrl

// ==== dv/link_host_model.sv ====
// Behavioural host on the two-wire link: clocks frames, releases the lines between them
`timescale 1ns/1ps
module link_host_model (
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Start, n clock pulses of 125 ns, stop; clock stands high between frames
    task automatic frame(input int n);
        sda_low = 1'b1;
        #62.5;
        for (int i = 0; i < n; i++) begin
            scl = 1'b0;
            sda_low = (i == n - 1) || i[0];
            #62.5;
            scl = 1'b1;
            #62.5;
        end
        sda_low = 1'b0;
        #62.5;
    endtask : frame
endmodule : link_host_model

// ==== dv/dual_temp_conversion_alarm_ctrl_tb.sv ====
// Self-checking bench of the sensor controller against a behavioural result model
`timescale 1ns/1ps
`include "temp_ctrl_defs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
$display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module dual_temp_conversion_alarm_ctrl_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic reset_pin = 1'b0;
    logic hw_standby_n = 1'b1;
    logic ot_sel = 1'b0;
    logic ot_open = 1'b0;
    logic alert_select = 1'b0;
    logic [1:0] crit_strap = 2'h3;
    logic [10:0] local_adc = 11'h0;
    logic [10:0] remote_adc = 11'h0;
    logic hready, hresp, diode, sda_out, sda_oe, ot_out, ot_oe, al_out, al_oe, scl, sda_low;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [2:0] adc_channel;
    logic [7:0] cfg = 8'h00;
    logic [31:0] last_l = 32'h0;
    logic [31:0] last_r = 32'h0;
    wire sda = ~(sda_low | sda_oe);
    int miscompares = 0;
    int samples_checked = 0;
    int rate = 2;
    int bad;
    // Columns: local C, remote C, strap, select, open, alarm, alert
    int tbl[10][7] = '{'{90, 20, 3, 0, 0, 1, 0}, '{90, 20, 3, 1, 0, 0, 0},
        '{90, 20, 3, 0, 1, 1, 0}, '{20, 90, 3, 1, 0, 1, 1}, '{20, 90, 3, 0, 0, 0, 1},
        '{82, 20, 0, 0, 0, 1, 0}, '{82, 20, 3, 0, 0, 0, 0}, '{20, 75, 3, 1, 1, 0, 1},
        '{85, 20, 2, 0, 0, 0, 0}, '{86, 20, 1, 0, 0, 1, 0}};
    always #5 hclk = ~hclk;
    dual_temp_conversion_alarm_ctrl #(.CONV_WINDOW_CYC(20), .RATE_8HZ_CYC(60))
        u_dual_temp_conversion_alarm_ctrl (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .reset_pin(reset_pin), .hw_standby_n(hw_standby_n),
        .overtemp_source_select(ot_sel), .overtemp_source_open(ot_open),
        .alert_select(alert_select), .crit_strap(crit_strap), .local_adc(local_adc),
        .remote_adc(remote_adc), .remote_diode_sub(diode), .adc_channel(adc_channel),
        .serial_clock_line(scl), .serial_data_line_in(sda), .serial_data_line_out(sda_out),
        .serial_data_line_oe(sda_oe), .overtemp_alarm_n_out(ot_out),
        .overtemp_alarm_n_oe(ot_oe), .alert_n_out(al_out), .alert_n_oe(al_oe));
    link_host_model u_link_host_model (.scl(scl), .sda_low(sda_low));
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic fail_wait();
        miscompares++;
        $display("[ERR] %0t wait bound used up", $time);
        conclude();
    endtask : fail_wait
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 40);
        rd = hrdata;
        if (n >= 40) fail_wait();
    endtask : ahb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask : rchk
    task automatic setcfg(input logic [7:0] v);
        cfg = v;
        wr(`OFS_CONFIG, {24'h0, v});
    endtask : setcfg
    task automatic wait_ch(input logic [2:0] v);
        int n;
        n = 0;
        while (adc_channel !== v && n < 1000) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 1000) fail_wait();
    endtask : wait_ch
    task automatic idle_for(input int cyc);
        bad = 0;
        repeat (cyc) begin
            @(posedge hclk);
            if (adc_channel !== 3'b001) bad++;
        end
    endtask : idle_for
    function automatic logic [31:0] exp_local(input int v);
        if (v < (cfg[3] ? -512 : 0)) v = cfg[3] ? -512 : 0;
        return {24'h0, 8'(v >>> 3)};
    endfunction : exp_local
    function automatic logic [31:0] exp_remote(input int v, input bit one);
        if (v < (cfg[3] ? -512 : 0)) v = cfg[3] ? -512 : 0;
        if (!(cfg[0] && (one || rate <= 2))) v = v & ~7;
        return {21'h0, 11'(v)};
    endfunction : exp_remote
    task automatic convert(input int l, input int r, input bit one);
        wait_ch(3'b001);
        local_adc <= l[10:0];
        remote_adc <= r[10:0];
        if (one) wr(`OFS_ONESHOT, $urandom);
        wait_ch(3'b010);
        if (one) begin
            ahb(1'b0, `OFS_STATUS, 32'h0);
            `CHK(rd[7], 1'b1)
            rchk(`OFS_LOCAL, last_l);
            rchk(`OFS_REMOTE, last_r);
        end
        wait_ch(3'b100);
        wait_ch(3'b001);
        last_l = exp_local(l);
        last_r = exp_remote(r, one);
        rchk(`OFS_LOCAL, last_l);
        rchk(`OFS_REMOTE, last_r);
    endtask : convert
    initial begin
        repeat (60000) @(posedge hclk);
        fail_wait();
    end
    initial begin
        void'($urandom(64898));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(`OFS_CONFIG, 32'h0);
        rchk(`OFS_RATE, 32'h2);
        rchk(`OFS_LOC_OT, 32'h55);
        rchk(`OFS_REM_OT, 32'h55);
        rchk(`OFS_REM_HIGH, 32'h46);
        rchk(`OFS_REM_LOW, 32'h0);
        rchk(8'h40, 32'h0);
        u_link_host_model.frame(9);
        wr(`OFS_LINK, 32'h0);
        rchk(`OFS_LINK, 32'h9);
        `CHK({sda_out, sda_oe, hresp}, 3'b000)
        setcfg(8'h40);
        repeat (3) @(posedge hclk);
        idle_for(300);
        `CHK(bad, 0)
        for (int i = 0; i < 4; i++) begin
            setcfg({4'h4, i[1], 2'b00, i[0]});
            convert(int'($urandom_range(2000)) - 1000, int'($urandom_range(2000)) - 1000, 1'b1);
            ahb(1'b0, `OFS_STATUS, 32'h0);
            `CHK(rd[7], 1'b0)
        end
        setcfg(8'h40);
        foreach (tbl[i]) begin
            crit_strap <= 2'(tbl[i][2]);
            ot_sel <= 1'(tbl[i][3]);
            ot_open <= 1'(tbl[i][4]);
            convert(tbl[i][0] * 8, tbl[i][1] * 8, 1'b1);
            `CHK(ot_oe, 1'(tbl[i][5]))
            `CHK(ot_out, 1'b0)
            `CHK(al_out, 1'b0)
            `CHK(al_oe, 1'(tbl[i][6]))
        end
        alert_select <= 1'b1;
        convert(160, 720, 1'b1);
        `CHK(al_oe, 1'b1)
        convert(160, 160, 1'b1);
        `CHK(al_oe, 1'b1)
        ahb(1'b0, `OFS_STATUS, 32'h0);
        `CHK(rd[2], 1'b1)
        repeat (2) @(posedge hclk);
        `CHK(al_oe, 1'b0)
        setcfg(8'hc0);
        convert(160, 720, 1'b1);
        `CHK(al_oe, 1'b0)
        setcfg(8'h01);
        for (int r = 3; r >= 0; r--) begin
            rate = r;
            wr(`OFS_RATE, 32'(r));
            convert(160, 725 - r, 1'b0);
        end
        hw_standby_n <= 1'b0;
        repeat (4) @(posedge hclk);
        idle_for(200);
        `CHK(bad, 0)
        wr(`OFS_ONESHOT, $urandom);
        idle_for(100);
        `CHK(bad, 0)
        rchk(`OFS_LOCAL, last_l);
        rchk(`OFS_CONFIG, 32'h01);
        hw_standby_n <= 1'b1;
        setcfg(8'h60);
        wr(`OFS_REM_HIGH, 32'h30);
        `CHK(diode, 1'b1)
        reset_pin <= 1'b1;
        repeat (6) @(posedge hclk);
        reset_pin <= 1'b0;
        repeat (4) @(posedge hclk);
        `CHK(diode, 1'b0)
        rchk(`OFS_CONFIG, 32'h0);
        rchk(`OFS_REM_HIGH, 32'h46);
        conclude();
    end
endmodule : dual_temp_conversion_alarm_ctrl_tb
